/* File: hdl/code_mem_cfg.svh */
`ifndef CODE_MEM_CFG_SVH
`define CODE_MEM_CFG_SVH

`define USER_BYTES        32768
`define BOOT_BYTES        2048
`define PAGE_BYTES        128
`define EXT_CYCLE_CLKS    6
`define ALE_LAST_PH       3'h1
`define BUS_LAST_PH       3'h5
`define PREFETCH_ADDR     16'h7fff
`define LAUNCH_ARM        4'h5
`define LAUNCH_GO         4'ha
`define FLASH_CONTROL_REG_BUSY_BIT     0
`define FLASH_CONTROL_REG_FMOD_LSB     1
`define FLASH_CONTROL_REG_FPS_BIT      3
`define FLASH_CONTROL_REG_FPL_LSB      4
`define FMOD_USER         2'h0
`define FMOD_EXTRA_ROW_SPACE         2'h1
`define FMOD_HSB          2'h2
`define FMOD_RSVD         2'h3
`define FLASH_CONTROL_REG_RESET        8'h00
`define HSB_FACTORY       8'hf0
`define LOCK_MAX_PROTECT  3'h0

`endif

/* File: hdl/code_mem_pkg.sv */
package code_mem_pkg;

    typedef enum logic [4:0] {
        BUS_IDLE  = 5'b00001,
        BUS_ADDR  = 5'b00010,
        BUS_HOLD  = 5'b00100,
        BUS_FLOAT = 5'b01000,
        BUS_STRB  = 5'b10000
    } bus_state_e;

    typedef enum logic [1:0] {
        PROG_IDLE  = 2'b01,
        PROG_SWEEP = 2'b10
    } prog_state_e;

    typedef enum logic [1:0] {
        RUN_USER = 2'h0,
        RUN_BOOT = 2'h1,
        RUN_EXT  = 2'h2
    } exec_region_e;

    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_LOAD = 2'h1,
        OP_CTRL = 2'h2
    } op_kind_e;

    typedef struct packed {
        logic [15:0] addr;
        logic        is_const;
    } fetch_req_s;

    typedef struct packed {
        op_kind_e    kind;
        logic [15:0] addr;
        logic [7:0]  data;
    } flash_op_s;

    typedef struct packed {
        logic        to_boot;
        logic [15:0] addr;
        logic [7:0]  data;
    } pp_write_s;

endpackage

/* File: hdl/code_memory_access_control.sv */
`timescale 1ns/1ps
`include "code_mem_cfg.svh"

// Notes on behaviour
// - External bus cycle lasts six CPU clocks
// - Low address on port zero, high on two
// - Port zero carries address, then returned data
// - Address strobe marks valid low address
// - Store strobe low only during external fetch
// - User array 256 pages of 128 bytes
// - Separate 128-byte extra row
// - Security byte: software writes upper nibble only
// - 128-byte column latch feeds all software writes
// - Programming launches only from boot flash
// - Boot flash written only by parallel programming
// - User code reads, loads; boot code also writes
// - External code denied flash reads, loads and launches
// - Boot flash mapped F800h-FFFFh when enabled
// - Boot flash holds 2 KB
// - Fetch at 7FFFh prefetches externally; reads not
// - Maximum protection refuses external execution
// - Busy flag set during programming, then cleared
module code_memory_access_control #(
    parameter int         USER_BYTES  = `USER_BYTES,
    parameter int         BOOT_BYTES  = `BOOT_BYTES,
    parameter int         PAGE_BYTES  = `PAGE_BYTES,
    parameter logic [7:0] HSB_FACTORY = `HSB_FACTORY
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      cpu_ce,
    input  wire logic                      fetch_valid,
    input  wire code_mem_pkg::fetch_req_s  fetch_req,
    input  wire code_mem_pkg::exec_region_e exec_region,
    input  wire logic                      external_access_select,
    input  wire logic                      boot_flash_map_enable,
    input  wire logic                      op_valid,
    input  wire code_mem_pkg::flash_op_s   op,
    input  wire logic                      pp_mode,
    input  wire logic                      pp_wr_valid,
    input  wire code_mem_pkg::pp_write_s   pp_wr,
    input  wire logic [7:0]                port_zero_in,
    output logic [7:0]                     port_zero_out,
    output logic                           port_zero_oe,
    output logic [7:0]                     port_two,
    output logic                           addr_latch_strobe,
    output logic                           program_store_strobe_n,
    output logic                           fetch_busy,
    output logic                           fetch_done,
    output logic [7:0]                     fetch_data,
    output logic                           fetch_refused,
    output logic                           op_done,
    output logic [7:0]                     op_data,
    output logic                           op_denied,
    output logic [7:0]                     flash_control_reg,
    output logic                           flash_program_busy
);
    localparam int UW = $clog2(USER_BYTES);
    localparam int BW = $clog2(BOOT_BYTES);
    localparam int PW = $clog2(PAGE_BYTES);
    localparam logic [PW-1:0] SWEEP_LAST = PW'(PAGE_BYTES - 1);

    // Flash arrays hold no reset: they stand for nonvolatile cells
    logic [7:0] user_mem [USER_BYTES];
    logic [7:0] extra_row_space_mem [PAGE_BYTES];
    logic [7:0] boot_mem [BOOT_BYTES];
    logic [7:0] latch_r  [PAGE_BYTES];
    logic       loaded_r [PAGE_BYTES];
    logic [7:0] hsb_r;

    code_mem_pkg::bus_state_e  bus_r;
    code_mem_pkg::bus_state_e  bus_nxt;
    code_mem_pkg::prog_state_e prog_r;
    code_mem_pkg::prog_state_e prog_nxt;
    logic [2:0]    ph_r;
    logic [2:0]    ph_nxt;
    logic [15:0]   ext_addr_r;
    logic          discard_r;
    logic [7:0]    flash_control_reg_r;
    logic          armed_r;
    logic [PW-1:0] sweep_r;
    logic [1:0]    tgt_r;
    logic [UW-PW-1:0] page_r;

    // Where the current code runs
    wire in_ext  = exec_region == code_mem_pkg::RUN_EXT;
    wire in_boot = exec_region == code_mem_pkg::RUN_BOOT;
    wire [1:0] fmod = flash_control_reg_r[`FLASH_CONTROL_REG_FMOD_LSB +: 2];
    wire       fps  = flash_control_reg_r[`FLASH_CONTROL_REG_FPS_BIT];
    wire       busy = prog_r == code_mem_pkg::PROG_SWEEP;

    // Fetch decode
    wire [15:0] f_addr     = fetch_req.addr;
    wire f_boot_hit = boot_flash_map_enable & (&f_addr[15:BW]);
    wire f_user_hit = external_access_select & ~f_addr[15] & ~f_boot_hit;
    wire f_internal = f_boot_hit | f_user_hit;
    wire lock_max   = hsb_r[2:0] == `LOCK_MAX_PROTECT;
    wire fetch_go   = cpu_ce & fetch_valid & ~fetch_busy;
    wire f_refuse   = fetch_go & ~f_internal & lock_max;
    // Only an opcode fetch at the top byte runs ahead onto the pins
    wire f_prefetch = f_user_hit & ~fetch_req.is_const
                      & (f_addr == `PREFETCH_ADDR);
    wire start_ext  = fetch_go & (f_prefetch | (~f_internal & ~lock_max));
    wire [15:0] ext_addr_sel = f_prefetch ? f_addr + 16'h0001 : f_addr;
    wire [15:0] ext_addr_nxt = (bus_r == code_mem_pkg::BUS_IDLE)
                               ? ext_addr_sel : ext_addr_r;
    wire [7:0] f_int_data = f_boot_hit ? boot_mem[f_addr[BW-1:0]]
                                       : user_mem[f_addr[UW-1:0]];
    wire bus_end  = (bus_r == code_mem_pkg::BUS_STRB)
                    & (ph_r == `BUS_LAST_PH);
    wire ext_done = bus_end & ~discard_r;

    // Bus sequence: address 2, hold 1, float 1, strobe 2 clocks
    always_comb begin
        bus_nxt = bus_r;
        case (bus_r)
            code_mem_pkg::BUS_IDLE: begin
                if (start_ext) begin
                    bus_nxt = code_mem_pkg::BUS_ADDR;
                end
            end
            code_mem_pkg::BUS_ADDR: begin
                if (ph_r == `ALE_LAST_PH) begin
                    bus_nxt = code_mem_pkg::BUS_HOLD;
                end
            end
            code_mem_pkg::BUS_HOLD:  bus_nxt = code_mem_pkg::BUS_FLOAT;
            code_mem_pkg::BUS_FLOAT: bus_nxt = code_mem_pkg::BUS_STRB;
            code_mem_pkg::BUS_STRB: begin
                if (ph_r == `BUS_LAST_PH) begin
                    bus_nxt = code_mem_pkg::BUS_IDLE;
                end
            end
            default: bus_nxt = code_mem_pkg::BUS_IDLE;
        endcase
    end

    assign ph_nxt = (bus_r == code_mem_pkg::BUS_IDLE) ? 3'h0 : ph_r + 3'h1;
    wire ale_nxt  = bus_nxt == code_mem_pkg::BUS_ADDR;
    // Port zero keeps the address one clock past the strobe's fall
    wire p0_oe_nxt = (bus_nxt == code_mem_pkg::BUS_ADDR)
                     | (bus_nxt == code_mem_pkg::BUS_HOLD);
    wire program_store_strobe_n_n_nxt = bus_nxt != code_mem_pkg::BUS_STRB;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus_r                  <= code_mem_pkg::BUS_IDLE;
            ph_r                   <= 3'h0;
            ext_addr_r             <= 16'h0000;
            discard_r              <= 1'b0;
            addr_latch_strobe      <= 1'b0;
            port_zero_oe           <= 1'b0;
            port_zero_out          <= 8'h00;
            port_two               <= 8'h00;
            program_store_strobe_n <= 1'b1;
            fetch_busy             <= 1'b0;
        end else if (cpu_ce) begin
            bus_r                  <= bus_nxt;
            ph_r                   <= ph_nxt;
            ext_addr_r             <= ext_addr_nxt;
            discard_r              <= start_ext ? f_prefetch : discard_r;
            addr_latch_strobe      <= ale_nxt;
            port_zero_oe           <= p0_oe_nxt;
            port_zero_out          <= ext_addr_nxt[7:0];
            port_two               <= ext_addr_nxt[15:8];
            program_store_strobe_n <= program_store_strobe_n_n_nxt;
            fetch_busy             <= bus_nxt != code_mem_pkg::BUS_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fetch_done    <= 1'b0;
            fetch_data    <= 8'h00;
            fetch_refused <= 1'b0;
        end else if (cpu_ce) begin
            fetch_done    <= (fetch_go & f_internal) | ext_done | f_refuse;
            fetch_data    <= ext_done ? port_zero_in : f_int_data;
            fetch_refused <= f_refuse;
        end
    end

    // Flash operation decode
    wire op_go   = cpu_ce & op_valid;
    wire is_rd   = op.kind == code_mem_pkg::OP_READ;
    wire is_ld   = op.kind == code_mem_pkg::OP_LOAD;
    wire is_ctrl = op.kind == code_mem_pkg::OP_CTRL;
    wire op_boot = boot_flash_map_enable & (&op.addr[15:BW])
                   & (fmod == `FMOD_USER);
    wire rd_ok = ~busy & ~in_ext & (fmod != `FMOD_RSVD)
                 & (~op_boot | in_boot);
    wire ld_ok = ~busy & ~in_ext & fps;
    wire [PW-1:0] ld_idx = (fmod == `FMOD_HSB) ? '0 : op.addr[PW-1:0];
    wire ld_go   = op_go & is_ld & ld_ok;
    wire go_nib  = op.data[`FLASH_CONTROL_REG_FPL_LSB +: 4] == `LAUNCH_GO;
    wire arm_nib = op.data[`FLASH_CONTROL_REG_FPL_LSB +: 4] == `LAUNCH_ARM;
    wire [1:0] op_fmod = op.data[`FLASH_CONTROL_REG_FMOD_LSB +: 2];
    // Any other operation between the two writes drops the arm
    wire launch = op_go & is_ctrl & go_nib & armed_r & in_boot & ~busy
                  & (op_fmod != `FMOD_RSVD);
    wire op_deny = op_go & ((is_rd & ~rd_ok) | (is_ld & ~ld_ok)
                   | (is_ctrl & go_nib & ~launch) | (~is_rd & ~is_ld
                   & ~is_ctrl));
    wire [7:0] rd_data = op_boot ? boot_mem[op.addr[BW-1:0]]
                       : (fmod == `FMOD_EXTRA_ROW_SPACE) ? extra_row_space_mem[op.addr[PW-1:0]]
                       : (fmod == `FMOD_HSB) ? hsb_r
                       : user_mem[op.addr[UW-1:0]];
    wire sweep_end = busy & (sweep_r == SWEEP_LAST);
    wire sweep_wr  = busy & loaded_r[sweep_r];

    always_comb begin
        prog_nxt = prog_r;
        case (prog_r)
            code_mem_pkg::PROG_IDLE: begin
                if (launch) begin
                    prog_nxt = code_mem_pkg::PROG_SWEEP;
                end
            end
            code_mem_pkg::PROG_SWEEP: begin
                if (sweep_end) begin
                    prog_nxt = code_mem_pkg::PROG_IDLE;
                end
            end
            default: prog_nxt = code_mem_pkg::PROG_IDLE;
        endcase
    end

    wire busy_nxt = prog_nxt == code_mem_pkg::PROG_SWEEP;
    wire [7:0] flash_control_reg_nxt = {(op_go & is_ctrl) ? op.data[7:1] : flash_control_reg_r[7:1],
                           busy_nxt};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prog_r            <= code_mem_pkg::PROG_IDLE;
            sweep_r           <= '0;
            tgt_r             <= `FMOD_USER;
            page_r            <= '0;
            flash_control_reg_r            <= `FLASH_CONTROL_REG_RESET;
            flash_control_reg <= `FLASH_CONTROL_REG_RESET;
            flash_program_busy <= 1'b0;
            armed_r           <= 1'b0;
            op_done           <= 1'b0;
            op_data           <= 8'h00;
            op_denied         <= 1'b0;
        end else if (cpu_ce) begin
            prog_r            <= prog_nxt;
            sweep_r           <= busy ? sweep_r + 1'b1 : '0;
            tgt_r             <= launch ? op_fmod : tgt_r;
            // Last page loaded picks the page that gets programmed
            page_r            <= (ld_go & (fmod == `FMOD_USER))
                                 ? op.addr[UW-1:PW] : page_r;
            flash_control_reg_r            <= flash_control_reg_nxt;
            flash_control_reg <= flash_control_reg_nxt;
            flash_program_busy <= busy_nxt;
            armed_r           <= op_go ? (is_ctrl & arm_nib) : armed_r;
            op_done           <= op_go;
            op_data           <= (op_go & is_rd & rd_ok) ? rd_data : 8'h00;
            op_denied         <= op_deny;
        end
    end

    // Column latch entries; a load beats the end-of-sweep clear
    for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_latch
        wire hit = ld_go & (ld_idx == PW'(i));
        always_ff @(posedge core_clk) begin
            if (rst) begin
                loaded_r[i] <= 1'b0;
                latch_r[i]  <= 8'h00;
            end else if (cpu_ce) begin
                loaded_r[i] <= hit | (loaded_r[i] & ~sweep_end);
                latch_r[i]  <= hit ? op.data : latch_r[i];
            end
        end
    end

    wire pp_go = cpu_ce & pp_wr_valid & pp_mode;

    always_ff @(posedge core_clk) begin
        if (cpu_ce & sweep_wr & (tgt_r == `FMOD_USER)) begin
            user_mem[{page_r, sweep_r}] <= latch_r[sweep_r];
        end
        if (cpu_ce & sweep_wr & (tgt_r == `FMOD_EXTRA_ROW_SPACE)) begin
            extra_row_space_mem[sweep_r] <= latch_r[sweep_r];
        end
        if (pp_go & pp_wr.to_boot) begin
            boot_mem[pp_wr.addr[BW-1:0]] <= pp_wr.data;
        end
    end

    // Low nibble of the security byte only moves in parallel mode
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hsb_r <= HSB_FACTORY;
        end else if (pp_go & ~pp_wr.to_boot) begin
            hsb_r <= pp_wr.data;
        end else if (cpu_ce & sweep_wr & (tgt_r == `FMOD_HSB)
                     & (sweep_r == '0)) begin
            hsb_r <= {latch_r[0][7:4], hsb_r[3:0]};
        end
    end

    logic [2:0] ext_len_r;
    always_ff @(posedge core_clk) begin
        if (rst | (bus_r == code_mem_pkg::BUS_IDLE)) begin
            ext_len_r <= 3'h0;
        end else if (cpu_ce) begin
            ext_len_r <= ext_len_r + 3'h1;
        end
    end
    wire [3:0] hsb_low = hsb_r[3:0];

    bus_len_a: assert property (@(posedge core_clk) disable iff (rst)
        (cpu_ce && bus_end) |-> ext_len_r == 3'(`EXT_CYCLE_CLKS - 1))
        else $error("external cycle length wrong");
    addr_valid_a: assert property (@(posedge core_clk) disable iff (rst)
        addr_latch_strobe |-> port_zero_oe
            && port_zero_out == ext_addr_r[7:0]
            && port_two == ext_addr_r[15:8])
        else $error("address not on pins under strobe");
    strobe_order_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(port_zero_oe) |-> !addr_latch_strobe
            && program_store_strobe_n && $past(!addr_latch_strobe))
        else $error("port zero released out of order");
    store_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
        !program_store_strobe_n |-> !port_zero_oe
            && bus_r == code_mem_pkg::BUS_STRB)
        else $error("store strobe outside external fetch");
    launch_boot_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(flash_program_busy) |-> $past(in_boot) && $past(armed_r))
        else $error("programming launched outside boot code");
    busy_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        (cpu_ce && sweep_end) |=> !flash_program_busy
            && !flash_control_reg[`FLASH_CONTROL_REG_BUSY_BIT])
        else $error("busy not cleared at end");
    ext_deny_a: assert property (@(posedge core_clk) disable iff (rst)
        (op_go && in_ext && !is_ctrl) |=> op_denied && op_data == 8'h00)
        else $error("external code reached flash");
    protect_refuse_a: assert property (@(posedge core_clk) disable iff (rst)
        (fetch_go && !f_internal && lock_max) |=> fetch_refused
            && fetch_done && bus_r == code_mem_pkg::BUS_IDLE)
        else $error("protected part ran external code");
    prefetch_top_a: assert property (@(posedge core_clk) disable iff (rst)
        (fetch_go && f_prefetch) |=> addr_latch_strobe
            && ext_addr_r == `PREFETCH_ADDR + 16'h0001 && fetch_done)
        else $error("top byte prefetch missing");
    hsb_low_a: assert property (@(posedge core_clk) disable iff (rst)
        !pp_go |=> hsb_low == $past(hsb_low))
        else $error("security low nibble changed by software");

endmodule // code_memory_access_control

/* File: bench/ext_code_mem.sv */
`timescale 1ns/1ps
module ext_code_mem (
    input  wire logic       core_clk,
    input  wire logic [7:0] addr_data_low,
    input  wire logic [7:0] port_two,
    input  wire logic       addr_latch_strobe,
    input  wire logic       program_store_strobe_n,
    output logic      [7:0] data_out
);
    logic [7:0] low_addr_r;
    logic [7:0] last_r = 8'h00;

    function automatic logic [7:0] content(input logic [15:0] a);
        return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h3c;
    endfunction

    // Address latch captures the low byte as the strobe falls
    always @(negedge addr_latch_strobe) low_addr_r <= addr_data_low;
    // Deselected lines toggle every cycle so a stale byte never matches
    always_comb data_out = program_store_strobe_n ? ~last_r
        : content({port_two, low_addr_r});
    always @(posedge core_clk) last_r <= data_out;
endmodule // ext_code_mem

/* File: bench/test_code_memory_access_control.sv */
`timescale 1ns/1ps
module test_code_memory_access_control;
    typedef struct packed {
        logic       chk;
        logic       flag;
        logic [7:0] data;
    } note_s;
    logic core_clk = 1'b0, rst = 1'b1, cpu_ce = 1'b1, fetch_valid = 1'b0;
    logic external_access_select = 1'b1, boot_flash_map_enable = 1'b0;
    logic op_valid = 1'b0, pp_mode = 1'b0, pp_wr_valid = 1'b0;
    code_mem_pkg::fetch_req_s   fetch_req = '0;
    code_mem_pkg::exec_region_e exec_region = code_mem_pkg::RUN_USER;
    code_mem_pkg::flash_op_s    op = '0;
    code_mem_pkg::pp_write_s    pp_wr = '0;
    wire  [7:0] port_zero_in, port_zero_out, port_two, fetch_data, op_data;
    wire  [7:0] flash_control_reg, mem_data;
    wire        port_zero_oe, addr_latch_strobe, program_store_strobe_n;
    wire        fetch_busy, fetch_done, fetch_refused, op_done, op_denied;
    wire        flash_program_busy;
    int         mismatches = 0, n_tests = 0, seed = 32'h6b5b, r, k;
    note_s      fq[$], oq[$], nt;

    always #50 core_clk = ~core_clk;
    assign port_zero_in = port_zero_oe ? port_zero_out : mem_data;

    code_memory_access_control DUT (.core_clk(core_clk), .rst(rst),
        .cpu_ce(cpu_ce), .fetch_valid(fetch_valid), .fetch_req(fetch_req),
        .exec_region(exec_region),
        .external_access_select(external_access_select),
        .boot_flash_map_enable(boot_flash_map_enable), .op_valid(op_valid),
        .op(op), .pp_mode(pp_mode), .pp_wr_valid(pp_wr_valid), .pp_wr(pp_wr),
        .port_zero_in(port_zero_in), .port_zero_out(port_zero_out),
        .port_zero_oe(port_zero_oe), .port_two(port_two),
        .addr_latch_strobe(addr_latch_strobe),
        .program_store_strobe_n(program_store_strobe_n),
        .fetch_busy(fetch_busy), .fetch_done(fetch_done),
        .fetch_data(fetch_data), .fetch_refused(fetch_refused),
        .op_done(op_done), .op_data(op_data), .op_denied(op_denied),
        .flash_control_reg(flash_control_reg),
        .flash_program_busy(flash_program_busy));
    ext_code_mem mem (.core_clk(core_clk), .addr_data_low(port_zero_out),
        .port_two(port_two), .addr_latch_strobe(addr_latch_strobe),
        .program_store_strobe_n(program_store_strobe_n), .data_out(mem_data));

    function automatic logic [7:0] exp_mem(input logic [15:0] a);
        return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h3c;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Oldest note pairs with each answer pulse
    always @(negedge core_clk) begin
        if (fetch_done === 1'b1) begin
            if (fq.size() == 0) chk(32'h1, 32'h0);
            else begin
                nt = fq.pop_front();
                chk(fetch_refused, nt.flag);
                if (nt.chk) chk(fetch_data, nt.data);
            end
        end
        if (op_done === 1'b1) begin
            if (oq.size() == 0) chk(32'h1, 32'h0);
            else begin
                nt = oq.pop_front();
                chk({op_denied, op_data}, {nt.flag, nt.data});
            end
        end
    end
    // mode: 0 no bus cycle, 1 full external walk, 2 top-address prefetch
    task automatic fetch(input logic [15:0] a, input logic c, input logic rf,
                         input logic ck, input logic [7:0] d, input int mode);
        int i;
        while (fetch_busy !== 1'b0) @(negedge core_clk);
        @(posedge core_clk);
        fetch_valid <= 1'b1;
        fetch_req <= {a, c};
        fq.push_back({ck, rf, d});
        @(posedge core_clk);
        fetch_valid <= 1'b0;
        for (i = 1; i <= 7; i++) begin
            @(negedge core_clk);
            if (mode == 0 && i == 1) chk({addr_latch_strobe, fetch_busy}, 0);
            if (mode == 2 && i == 1) chk({addr_latch_strobe, port_two}, 9'h180);
            if (mode == 1) chk({addr_latch_strobe, port_zero_oe,
                program_store_strobe_n, fetch_busy},
                {i <= 2, i <= 3, !(i == 5 || i == 6), i <= 6});
            if (mode == 1 && i == 1) chk({port_two, port_zero_out}, a);
        end
    endtask
    task automatic do_op(input code_mem_pkg::op_kind_e kd, input logic [15:0] a,
                         input logic [7:0] d, input logic den,
                         input logic [7:0] rd);
        @(posedge core_clk);
        op_valid <= 1'b1;
        op <= {kd, a, d};
        oq.push_back({1'b1, den, rd});
        @(posedge core_clk);
        op_valid <= 1'b0;
    endtask
    task automatic launch(input logic [3:0] sp, input logic [7:0] fc);
        int n;
        n = 0;
        do_op(code_mem_pkg::OP_CTRL, 0, {4'h5, sp}, 0, 0);
        do_op(code_mem_pkg::OP_CTRL, 0, {4'ha, sp}, 0, 0);
        while (flash_program_busy !== 1'b1 && n < 4) begin
            @(negedge core_clk);
            n++;
        end
        chk(flash_control_reg, fc);
        n = 0;
        while (flash_program_busy === 1'b1 && n < 1000) begin
            @(negedge core_clk);
            n++;
        end
        chk(n, 128);
        chk(flash_control_reg[0], 0);
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk({program_store_strobe_n, addr_latch_strobe, port_zero_oe,
             fetch_busy, flash_program_busy, flash_control_reg}, 13'h1000);
        fetch(16'h9000, 0, 1, 0, 0, 0);
        @(posedge core_clk);
        pp_mode <= 1'b1;
        pp_wr_valid <= 1'b1;
        pp_wr <= {1'b0, 16'h0000, 8'hf7};
        @(posedge core_clk);
        pp_wr <= {1'b1, 16'h0100, 8'hc3};
        @(posedge core_clk);
        pp_wr_valid <= 1'b0;
        pp_mode <= 1'b0;
        for (k = 0; k < 5; k++) begin
            r = $random(seed);
            if (k == 4) begin
                @(posedge core_clk);
                external_access_select <= 1'b0;
            end
            fetch({k < 4, r[14:0]}, 0, 0, 1, exp_mem({k < 4, r[14:0]}), 1);
        end
        @(posedge core_clk);
        external_access_select <= 1'b1;
        // Launch from user code and an interrupted sequence both fail
        do_op(code_mem_pkg::OP_CTRL, 0, 8'h50, 0, 0);
        do_op(code_mem_pkg::OP_CTRL, 0, 8'ha0, 1, 0);
        chk(flash_program_busy, 0);
        exec_region <= code_mem_pkg::RUN_BOOT;
        do_op(code_mem_pkg::OP_CTRL, 0, 8'h08, 0, 0);
        do_op(code_mem_pkg::OP_LOAD, 16'h1234, 8'h5a, 0, 0);
        do_op(code_mem_pkg::OP_CTRL, 0, 8'h58, 0, 0);
        do_op(code_mem_pkg::OP_LOAD, 16'h1235, 8'h11, 0, 0);
        do_op(code_mem_pkg::OP_CTRL, 0, 8'ha8, 1, 0);
        launch(4'h8, 8'ha9);
        do_op(code_mem_pkg::OP_LOAD, 16'h0000, 8'h3a, 0, 0);
        launch(4'hc, 8'had);
        do_op(code_mem_pkg::OP_CTRL, 0, 8'h0a, 0, 0);
        do_op(code_mem_pkg::OP_LOAD, 16'hff85, 8'h96, 0, 0);
        launch(4'ha, 8'hab);
        do_op(code_mem_pkg::OP_CTRL, 0, 8'h02, 0, 0);
        do_op(code_mem_pkg::OP_READ, 16'hff85, 0, 0, 8'h96);
        do_op(code_mem_pkg::OP_CTRL, 0, 8'h04, 0, 0);
        do_op(code_mem_pkg::OP_READ, 0, 0, 0, 8'h37);
        do_op(code_mem_pkg::OP_CTRL, 0, 8'h06, 0, 0);
        do_op(code_mem_pkg::OP_READ, 0, 0, 1, 0);
        do_op(code_mem_pkg::OP_CTRL, 0, 8'h00, 0, 0);
        boot_flash_map_enable <= 1'b1;
        do_op(code_mem_pkg::OP_READ, 16'hf900, 0, 0, 8'hc3);
        exec_region <= code_mem_pkg::RUN_USER;
        boot_flash_map_enable <= 1'b1;
        do_op(code_mem_pkg::OP_READ, 16'h1234, 0, 0, 8'h5a);
        do_op(code_mem_pkg::OP_READ, 16'hf900, 0, 1, 0);
        fetch(16'hf900, 0, 0, 1, 8'hc3, 0);
        do_op(code_mem_pkg::OP_LOAD, 16'h1234, 8'h22, 1, 0);
        exec_region <= code_mem_pkg::RUN_EXT;
        do_op(code_mem_pkg::OP_READ, 16'h1234, 0, 1, 0);
        do_op(code_mem_pkg::OP_CTRL, 0, 8'h08, 0, 0);
        do_op(code_mem_pkg::OP_LOAD, 16'h1234, 8'h22, 1, 0);
        exec_region <= code_mem_pkg::RUN_USER;
        boot_flash_map_enable <= 1'b0;
        fetch(16'h1234, 0, 0, 1, 8'h5a, 0);
        fetch(16'h7fff, 1, 0, 0, 0, 0);
        fetch(16'h7fff, 0, 0, 0, 0, 2);
        // Clock enable low must swallow a request and leave the control register unchanged
        @(posedge core_clk);
        cpu_ce <= 1'b0;
        op_valid <= 1'b1;
        op <= {code_mem_pkg::OP_CTRL, 16'h0000, 8'h50};
        repeat (3) @(posedge core_clk);
        op_valid <= 1'b0;
        cpu_ce <= 1'b1;
        @(negedge core_clk);
        chk({op_done, flash_control_reg}, 9'h008);
        repeat (10) @(negedge core_clk);
        chk(fq.size() + oq.size(), 0);
        results();
    end
    initial begin
        #(20000 * 100);
        mismatches++;
        results();
    end
endmodule // test_code_memory_access_control
